// ---- design/frx_pkg.sv ----
// package: constants for the fsk receive-side control block
// assumes a 125 MHz clock; all timing counts derive from that rate
`default_nettype none
package frx_pkg;
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned CAL_TIME_MS   = 10;
  localparam int unsigned CAL_CYCLES    = CAL_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned TX_BASE_NS    = 5000;
  localparam int unsigned TX_BASE_CYC   = (TX_BASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TOUT_BITS     = 16;
  localparam int unsigned PRE_BITS_BYTE = 8;
  localparam logic [1:0]  PRE_LEN_1B    = 2'h0;
  localparam logic [1:0]  PRE_LEN_2B    = 2'h1;
  localparam logic [1:0]  PRE_LEN_3B    = 2'h2;
  localparam logic [2:0]  TRIG_NONE     = 3'h0;
  localparam logic [2:0]  TRIG_LVL      = 3'h1;
  localparam logic [2:0]  TRIG_PRE      = 3'h6;
  localparam logic [2:0]  TRIG_BOTH     = 3'h7;
  localparam logic [2:0]  MODE_SLEEP    = 3'h0;
  localparam logic [2:0]  MODE_STDBY    = 3'h1;
  localparam logic [2:0]  MODE_SYNTH_TX_MODE     = 3'h2;
  localparam logic [2:0]  MODE_TX       = 3'h3;
  localparam logic [2:0]  MODE_SYNTH_RX_MODE     = 3'h4;
  localparam logic [2:0]  MODE_RX       = 3'h5;
  localparam int unsigned TEMP_STEP_C   = 5;
  localparam int unsigned BW_STEPS      = 21;
  // receiver startup per bandwidth index, us, narrowest first
  localparam int unsigned RX_START_US [BW_STEPS] = '{
    2330, 1940, 1560, 1180, 984, 791, 601, 504, 407, 313, 264,
    215, 169, 144, 119, 97, 84, 71, 85, 74, 63};
  typedef enum logic [2:0] {
    FRX_OFF, FRX_OSC, FRX_SYN, FRX_BLK, FRX_READY
  } frx_seq_t;
  function automatic logic [31:0] frx_us_to_cyc(input int unsigned us);
    frx_us_to_cyc = 32'(us * CLK_MHZ);
  endfunction
endpackage
`default_nettype wire

// ---- design/frx_tout.sv ----
// one receive timeout counter in units of sixteen bit periods
// assumes bit_tick pulses once per bit period
`default_nettype none
module frx_tout
  import frx_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         rx_on,
  input  wire logic         armed,
  input  wire logic         bit_tick,
  input  wire logic         seen,
  input  wire logic [W-1:0] limit,
  output logic              expired
);
  logic [3:0]   sub_q, sub_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic         done_q, done_d;
  logic         exp_q, exp_d;

  always_comb begin
    sub_d  = sub_q;
    cnt_d  = cnt_q;
    done_d = done_q;
    exp_d  = 1'b0;
    if (!rx_on) begin
      sub_d  = 4'h0;
      cnt_d  = '0;
      done_d = 1'b0;
    end else if (seen) begin
      done_d = 1'b1;
    end else if (armed && !done_q && limit != '0 && bit_tick) begin
      sub_d = sub_q + 4'h1;
      if (sub_q == 4'(TOUT_BITS - 1)) begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 == limit) begin
          exp_d  = 1'b1;
          done_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sub_q  <= 4'h0;
      cnt_q  <= '0;
      done_q <= 1'b0;
      exp_q  <= 1'b0;
    end else if (ce) begin
      sub_q  <= sub_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      exp_q  <= exp_d;
    end
  end
  assign expired = exp_q;

  a_expire_needs_arm: assert property (@(posedge clk) disable iff (rst)
    ce && exp_d |-> armed && rx_on && !seen)
    else $error("timeout fired while not armed");
endmodule
`default_nettype wire

// ---- design/frx_ctrl.sv ----
// receive-side control: preamble detect, calibration, timeouts, mode sequencing
// assumes demod bits arrive with bit_tick; all inputs synchronous to clk
`default_nettype none
// Function
// - preamble run length is 1, 2 or 3 bytes by a two-bit select; 11 reserved.
// - when detector enabled, raise preamble-found flag on each valid preamble.
// - preamble-found gates automatic gain and frequency correction.
// - start calibration after power-on and manual reset.
// - software trigger starts calibration only in standby and fsk mode.
// - with monitoring on, flag temperature shifts beyond selected step.
// - temperature change starts calibration when auto calibration enabled.
// - a calibration run lasts about 10 ms.
// - level timeout after limit times 16 bits without level flag.
// - preamble timeout after limit times 16 bits without preamble flag.
// - sync timeout after limit times 16 bits without sync match.
// - receive trigger 001, 110, 111 arm timeout pairs; 000 none.
// - mode codes: sleep, standby, synth tx, tx, synth rx, rx.
// - synth tuned to carrier in tx, carrier minus if in rx.
// - mode changes power sub-blocks up in fixed order.
// - from sleep wait oscillator then synthesizer startup.
// - fsk tx startup is 5 us plus 1.25 ramp plus half bit.
// - ook tx startup is 5 us plus half bit.
// - rx startup uses correction bandwidth when auto correction enabled.
// - rx startup follows bandwidth table, 2.33 ms down to 63 us.
// - after rx startup elapses, packets are detected and demodulated.
module frx_ctrl
  import frx_pkg::*;
#(
  parameter int unsigned CAL_CYC  = CAL_CYCLES,
  parameter int unsigned OSC_CYC  = 8192,
  parameter int unsigned SYN_CYC  = 8192,
  parameter int unsigned TW       = 8,
  parameter int unsigned FW       = 24
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          bit_tick,
  input  wire logic [15:0]   half_bit_cyc,
  input  wire logic          demod_bit,
  input  wire logic          demod_valid,
  input  wire logic          preamble_detector_enable,
  input  wire logic [1:0]    preamble_length_select,
  input  wire logic [4:0]    preamble_error_tolerance,
  input  wire logic          image_cal_trigger,
  input  wire logic          long_range_mode,
  input  wire logic          temp_watch_disable,
  input  wire logic [1:0]    temp_delta_select,
  input  wire logic          auto_image_cal_enable,
  input  wire logic [7:0]    temp_reading,
  input  wire logic [7:0]    signal_level_value,
  input  wire logic [7:0]    signal_level_limit,
  input  wire logic          sync_match_flag,
  input  wire logic [2:0]    receive_trigger_select,
  input  wire logic [TW-1:0] level_wait_limit,
  input  wire logic [TW-1:0] preamble_wait_limit,
  input  wire logic [TW-1:0] sync_wait_limit,
  input  wire logic [2:0]    op_mode_sel,
  input  wire logic          ook_select,
  input  wire logic [15:0]   pa_ramp_time_cyc,
  input  wire logic          auto_freq_correct_enable,
  input  wire logic [4:0]    rx_bandwidth,
  input  wire logic [4:0]    correction_bw_setting,
  input  wire logic [FW-1:0] carrier_word,
  input  wire logic [FW-1:0] if_word,
  output logic               preamble_found_flag,
  output logic               correction_gate,
  output logic               cal_busy,
  output logic               temp_shift_flag,
  output logic               level_flag,
  output logic               timeout_level,
  output logic               timeout_preamble,
  output logic               timeout_sync,
  output logic [FW-1:0]      synth_word,
  output logic               osc_on,
  output logic               synth_on,
  output logic               tx_on,
  output logic               rx_on,
  output logic               mode_ready,
  output logic               rx_demod_enable
);
  function automatic logic [31:0] rx_start_cyc(input logic [4:0] idx);
    rx_start_cyc = (idx < 5'(BW_STEPS)) ? frx_us_to_cyc(RX_START_US[idx])
                                        : frx_us_to_cyc(RX_START_US[BW_STEPS-1]);
  endfunction

  // preamble run counter
  logic [4:0] run_q, run_d;
  logic       last_q, last_d;
  logic       pre_q, pre_d;
  logic [4:0] need;
  always_comb begin
    case (preamble_length_select)
      PRE_LEN_1B: need = 5'(PRE_BITS_BYTE);
      PRE_LEN_2B: need = 5'(2 * PRE_BITS_BYTE);
      PRE_LEN_3B: need = 5'(3 * PRE_BITS_BYTE);
      default:    need = 5'h1F;
    endcase
    run_d  = run_q;
    last_d = last_q;
    pre_d  = pre_q;
    if (!rx_on) begin
      run_d = 5'h0;
      pre_d = 1'b0;
    end else if (demod_valid) begin
      last_d = demod_bit;
      run_d  = (demod_bit != last_q) ? ((run_q == 5'h1F) ? run_q : run_q + 5'h1) : 5'h0;
      if (preamble_detector_enable && preamble_length_select != 2'h3
          && run_d >= need)
        pre_d = 1'b1;
      else if (run_d == 5'h0)
        pre_d = 1'b0;
    end
  end
  assign preamble_found_flag = pre_q;
  assign correction_gate     = pre_q && rx_demod_enable;

  // calibration timer and temperature watch
  logic [31:0] cal_q, cal_d;
  logic [7:0]  tref_q, tref_d;
  logic        tflag_q, tflag_d;
  logic        boot_q, boot_d;
  logic [7:0]  tdiff;
  logic        tshift;
  always_comb begin
    tdiff  = (temp_reading > tref_q) ? temp_reading - tref_q : tref_q - temp_reading;
    tshift = !temp_watch_disable &&
             tdiff > 8'((32'(temp_delta_select) + 1) * TEMP_STEP_C);
    cal_d   = (cal_q != 0) ? cal_q - 1 : 0;
    tref_d  = tref_q;
    tflag_d = tflag_q;
    boot_d  = 1'b0;
    if (boot_q) begin
      cal_d  = CAL_CYC;
      tref_d = temp_reading;
    end
    if (image_cal_trigger && op_mode_sel == MODE_STDBY && !long_range_mode)
      cal_d = CAL_CYC;
    if (tshift) begin
      tflag_d = 1'b1;
      tref_d  = temp_reading;
      if (auto_image_cal_enable)
        cal_d = CAL_CYC;
    end else if (temp_watch_disable) begin
      tflag_d = 1'b0;
    end
  end
  assign cal_busy        = cal_q != 0;
  assign temp_shift_flag = tflag_q;

  // mode sequencing
  frx_seq_t    st_q, st_d;
  logic [31:0] wait_q, wait_d;
  logic [2:0]  cur_q, cur_d;
  logic [31:0] blk_cyc;
  logic [4:0]  bw_sel;
  always_comb begin
    bw_sel = auto_freq_correct_enable ? correction_bw_setting : rx_bandwidth;
    if (op_mode_sel == MODE_RX)
      blk_cyc = rx_start_cyc(bw_sel);
    else if (ook_select)
      blk_cyc = 32'(TX_BASE_CYC) + 32'(half_bit_cyc);
    else
      blk_cyc = 32'(TX_BASE_CYC) + 32'(half_bit_cyc) + 32'(pa_ramp_time_cyc)
              + (32'(pa_ramp_time_cyc) >> 2);
    st_d   = st_q;
    wait_d = (wait_q != 0) ? wait_q - 1 : 0;
    cur_d  = cur_q;
    if (op_mode_sel != cur_q) begin
      cur_d = op_mode_sel;
      case (op_mode_sel)
        MODE_SLEEP: begin
          st_d = FRX_OFF;
          wait_d = 0;
        end
        MODE_STDBY: begin
          st_d = (st_q == FRX_OFF) ? FRX_OSC : FRX_READY;
          wait_d = (st_q == FRX_OFF) ? OSC_CYC : 0;
        end
        default: begin
          st_d = (st_q == FRX_OFF) ? FRX_OSC : FRX_SYN;
          wait_d = (st_q == FRX_OFF) ? OSC_CYC : SYN_CYC;
        end
      endcase
    end else if (wait_q == 0) begin
      case (st_q)
        FRX_OSC: begin
          st_d = (cur_q == MODE_STDBY) ? FRX_READY : FRX_SYN;
          wait_d = (cur_q == MODE_STDBY) ? 0 : SYN_CYC;
        end
        FRX_SYN: begin
          st_d = (cur_q == MODE_TX || cur_q == MODE_RX) ? FRX_BLK : FRX_READY;
          wait_d = (cur_q == MODE_TX || cur_q == MODE_RX) ? blk_cyc : 0;
        end
        FRX_BLK: st_d = FRX_READY;
        default: st_d = st_q;
      endcase
    end
  end
  assign osc_on   = st_q != FRX_OFF;
  assign synth_on = cur_q >= MODE_SYNTH_TX_MODE && cur_q <= MODE_RX
                    && (st_q == FRX_SYN || st_q == FRX_BLK || st_q == FRX_READY);
  assign tx_on    = cur_q == MODE_TX && (st_q == FRX_BLK || st_q == FRX_READY);
  assign rx_on    = cur_q == MODE_RX && (st_q == FRX_BLK || st_q == FRX_READY);
  assign mode_ready      = st_q == FRX_READY || (st_q == FRX_OFF && cur_q == MODE_SLEEP);
  assign rx_demod_enable = rx_on && st_q == FRX_READY;

  logic [FW-1:0] syn_q, syn_d;
  always_comb begin
    case (cur_q)
      MODE_SYNTH_RX_MODE, MODE_RX: syn_d = carrier_word - if_word;
      default:            syn_d = carrier_word;
    endcase
  end
  assign synth_word = syn_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q   <= 5'h0;
      last_q  <= 1'b0;
      pre_q   <= 1'b0;
      cal_q   <= 32'h0;
      tref_q  <= 8'h0;
      tflag_q <= 1'b0;
      boot_q  <= 1'b1;
      st_q    <= FRX_OFF;
      wait_q  <= 32'h0;
      cur_q   <= MODE_SLEEP;
      syn_q   <= '0;
    end else if (ce) begin
      run_q   <= run_d;
      last_q  <= last_d;
      pre_q   <= pre_d;
      cal_q   <= cal_d;
      tref_q  <= tref_d;
      tflag_q <= tflag_d;
      boot_q  <= boot_d;
      st_q    <= st_d;
      wait_q  <= wait_d;
      cur_q   <= cur_d;
      syn_q   <= syn_d;
    end
  end

  // timeouts
  logic lvl_arm, pre_arm, syn_arm;
  assign level_flag = signal_level_value > signal_level_limit;
  assign lvl_arm = receive_trigger_select == TRIG_LVL || receive_trigger_select == TRIG_BOTH;
  assign pre_arm = receive_trigger_select == TRIG_PRE || receive_trigger_select == TRIG_BOTH;
  assign syn_arm = receive_trigger_select == TRIG_LVL || receive_trigger_select == TRIG_PRE;

  frx_tout #(.W(TW)) u_lvl (.clk(clk), .rst(rst), .ce(ce), .rx_on(rx_on), .armed(lvl_arm),
    .bit_tick(bit_tick), .seen(level_flag), .limit(level_wait_limit),
    .expired(timeout_level));
  frx_tout #(.W(TW)) u_pre (.clk(clk), .rst(rst), .ce(ce), .rx_on(rx_on), .armed(pre_arm),
    .bit_tick(bit_tick), .seen(pre_q), .limit(preamble_wait_limit),
    .expired(timeout_preamble));
  frx_tout #(.W(TW)) u_syn (.clk(clk), .rst(rst), .ce(ce), .rx_on(rx_on), .armed(syn_arm),
    .bit_tick(bit_tick), .seen(sync_match_flag), .limit(sync_wait_limit),
    .expired(timeout_sync));

  a_cal_after_reset: assert property (@(posedge clk) disable iff (rst)
    ce && boot_q |=> cal_busy)
    else $error("no calibration after reset");
  a_pre_needs_enable: assert property (@(posedge clk) disable iff (rst)
    ce && $rose(pre_q) |-> $past(preamble_detector_enable))
    else $error("preamble flag without enable");
  a_gate_follows: assert property (@(posedge clk) disable iff (rst)
    correction_gate |-> preamble_found_flag)
    else $error("correction without preamble");
  a_no_trig_none: assert property (@(posedge clk) disable iff (rst)
    receive_trigger_select == TRIG_NONE |-> !(lvl_arm || pre_arm || syn_arm))
    else $error("timeout armed with no trigger");
  a_rx_tuning: assert property (@(posedge clk) disable iff (rst)
    ce && cur_q == MODE_RX && $stable(carrier_word) && $stable(if_word)
    |=> synth_word == carrier_word - if_word)
    else $error("rx tuning wrong");
  a_sleep_off: assert property (@(posedge clk) disable iff (rst)
    ce && op_mode_sel == MODE_SLEEP |=> !osc_on)
    else $error("oscillator on in sleep");
  a_wake_order: assert property (@(posedge clk) disable iff (rst)
    ce && st_q == FRX_OFF && op_mode_sel == MODE_RX |=> st_q == FRX_OSC && !synth_on)
    else $error("wake order wrong");
  a_temp_auto_cal: assert property (@(posedge clk) disable iff (rst)
    ce && tshift && auto_image_cal_enable |=> cal_busy)
    else $error("temp change did not recalibrate");
  a_user_cal_start: assert property (@(posedge clk) disable iff (rst)
    ce && image_cal_trigger && op_mode_sel == MODE_STDBY && !long_range_mode |=> cal_busy)
    else $error("user calibration not started");
  a_temp_flag_off: assert property (@(posedge clk) disable iff (rst)
    ce && temp_watch_disable |=> !temp_shift_flag)
    else $error("temperature flag set while watch off");
  a_demod_after_start: assert property (@(posedge clk) disable iff (rst)
    ce && st_q == FRX_BLK && wait_q != 0 |=> !rx_demod_enable)
    else $error("demodulation before startup elapsed");
  a_tx_off_rx: assert property (@(posedge clk) disable iff (rst)
    ce && op_mode_sel == MODE_RX |=> !tx_on)
    else $error("transmitter on in receive");
  a_rx_block_wait: assert property (@(posedge clk) disable iff (rst)
    ce && st_q == FRX_SYN && wait_q == 0 && cur_q == MODE_RX && op_mode_sel == MODE_RX
    |=> st_q == FRX_BLK)
    else $error("receiver startup wait skipped");
endmodule
`default_nettype wire

// ---- dv/frx_bit_src.sv ----
// partner: bit timing and demodulated bit stream from the far side
// assumes the bench clock; bits alternate while alt is high
`default_nettype none
module frx_bit_src #(
  parameter int unsigned BIT_CYC = 4
) (
  input  wire logic clk,
  input  wire logic alt,
  output logic      bit_tick,
  output logic      demod_bit,
  output logic      demod_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt  = 0;
  logic        last = 1'b0;
  initial begin
    bit_tick = 1'b0;
    demod_bit = 1'b0;
    demod_valid = 1'b0;
  end
  // one valid bit per period, inverse level in between
  always @(negedge clk) begin
    cnt = (cnt + 1) % BIT_CYC;
    bit_tick <= (cnt == 0);
    demod_valid <= (cnt == 0);
    if (cnt == 0) begin
      last = alt ? ~last : 1'b1;
      demod_bit <= last;
    end else begin
      demod_bit <= ~last;
    end
  end
endmodule
`default_nettype wire

// ---- dv/frx_ctrl_tb_top.sv ----
// bench top: drives the receive control block and judges its ports
// assumes frx_bit_src supplies bit ticks at four clocks per bit
`default_nettype none
module frx_ctrl_tb_top import frx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 100;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, alt = 1'b0;
  logic bit_tick, demod_bit, demod_valid;
  logic preamble_found_flag, correction_gate, cal_busy, temp_shift_flag, level_flag;
  logic timeout_level, timeout_preamble, timeout_sync, osc_on, synth_on, tx_on, rx_on;
  logic mode_ready, rx_demod_enable;
  logic [23:0] synth_word;
  logic [15:0] half_bit_cyc = 16'h0002, pa_ramp_time_cyc = 16'h0190;
  logic preamble_detector_enable = 1'b1, image_cal_trigger = 1'b0, long_range_mode = 1'b0;
  logic temp_watch_disable = 1'b1, auto_image_cal_enable = 1'b0, sync_match_flag = 1'b0;
  logic ook_select = 1'b0, auto_freq_correct_enable = 1'b1;
  logic [1:0] preamble_length_select = 2'h1, temp_delta_select = 2'h1;
  logic [4:0] preamble_error_tolerance = 5'h0A;
  logic [4:0] rx_bandwidth = 5'h00, correction_bw_setting = 5'h14;
  logic [7:0] temp_reading = 8'h19, signal_level_value = 8'h40, signal_level_limit = 8'h50;
  logic [7:0] level_wait_limit = 8'h00, preamble_wait_limit = 8'h00, sync_wait_limit = 8'h00;
  logic [2:0] receive_trigger_select = TRIG_NONE, op_mode_sel = MODE_SLEEP;
  logic [23:0] carrier_word = 24'h6C8000, if_word = 24'h001000;
  int fails = 0;
  int tests_run = 0;
  int n;

  always #4 clk = ~clk;

  frx_bit_src #(.BIT_CYC(4)) u_frx_bit_src (.clk, .alt, .bit_tick, .demod_bit, .demod_valid);

  frx_ctrl #(.CAL_CYC(CAL), .OSC_CYC(8), .SYN_CYC(8)) u_frx_ctrl (
    .clk, .rst, .ce, .bit_tick, .half_bit_cyc, .demod_bit, .demod_valid,
    .preamble_detector_enable, .preamble_length_select, .preamble_error_tolerance,
    .image_cal_trigger, .long_range_mode, .temp_watch_disable, .temp_delta_select,
    .auto_image_cal_enable, .temp_reading, .signal_level_value, .signal_level_limit,
    .sync_match_flag, .receive_trigger_select, .level_wait_limit, .preamble_wait_limit,
    .sync_wait_limit, .op_mode_sel, .ook_select, .pa_ramp_time_cyc,
    .auto_freq_correct_enable, .rx_bandwidth, .correction_bw_setting, .carrier_word,
    .if_word, .preamble_found_flag, .correction_gate, .cal_busy, .temp_shift_flag,
    .level_flag, .timeout_level, .timeout_preamble, .timeout_sync, .synth_word, .osc_on,
    .synth_on, .tx_on, .rx_on, .mode_ready, .rx_demod_enable);

  task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %0h", $time, m, got);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string m);
    tests_run++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD t=%0t %s count %0d", $time, m, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_lv(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic enter_rx();
    int k;
    op_mode_sel = MODE_STDBY;
    cyc(4);
    op_mode_sel = MODE_RX;
    wait_lv(rx_on, 1'b1, 40, k);
  endtask

  task automatic t_boot(input int hold);
    wait_lv(cal_busy, 1'b1, 5, n);
    ce = 1'b0;
    cyc(hold);
    chk_vec(cal_busy, 1, "cal held while frozen");
    ce = 1'b1;
    wait_lv(cal_busy, 1'b0, 300, n);
    chk_rng(n, CAL - 2, CAL + 1, "boot cal length");
  endtask

  task automatic t_cal();
    for (int i = 0; i < 3; i++) begin
      op_mode_sel = (i == 2) ? MODE_SLEEP : MODE_STDBY;
      long_range_mode = (i == 0);
      cyc(20);
      image_cal_trigger = 1'b1;
      cyc(1);
      image_cal_trigger = 1'b0;
      cyc(2);
      chk_vec(cal_busy, i == 1, "user cal start");
      wait_lv(cal_busy, 1'b0, 300, n);
    end
  endtask

  task automatic t_temp();
    op_mode_sel = MODE_STDBY;
    temp_reading = 8'h3C;
    cyc(4);
    chk_vec(temp_shift_flag, 0, "temp flag while off");
    temp_reading = 8'h19;
    cyc(4);
    temp_watch_disable = 1'b0;
    temp_reading = 8'h22;
    cyc(4);
    chk_vec(temp_shift_flag, 0, "temp flag below step");
    temp_reading = 8'h24;
    cyc(4);
    chk_vec(temp_shift_flag, 1, "temp flag over step");
    chk_vec(cal_busy, 0, "no auto cal");
    temp_watch_disable = 1'b1;
    cyc(4);
    chk_vec(temp_shift_flag, 0, "temp flag cleared");
    auto_image_cal_enable = 1'b1;
    temp_watch_disable = 1'b0;
    cyc(4);
    chk_vec(cal_busy, 0, "no cal without shift");
    temp_reading = 8'h19;
    cyc(4);
    chk_vec(temp_shift_flag, 1, "temp flag again");
    chk_vec(cal_busy, 1, "auto cal on shift");
    wait_lv(cal_busy, 1'b0, 300, n);
  endtask

  task automatic t_modes();
    op_mode_sel = MODE_SLEEP;
    cyc(4);
    chk_vec(osc_on, 0, "sleep osc");
    op_mode_sel = MODE_RX;
    wait_lv(osc_on, 1'b1, 4, n);
    chk_vec(osc_on, 1, "osc after wake");
    chk_vec(synth_on, 0, "synth before osc done");
    wait_lv(synth_on, 1'b1, 20, n);
    chk_rng(n, 7, 9, "osc wait");
    wait_lv(rx_on, 1'b1, 20, n);
    chk_rng(n, 7, 9, "synth wait");
    chk_vec(rx_demod_enable, 0, "demod early");
    wait_lv(mode_ready, 1'b1, 9000, n);
    chk_rng(n, 7481, 8269, "rx startup");
    chk_vec(rx_demod_enable, 1, "demod after startup");
    op_mode_sel = MODE_SYNTH_TX_MODE;
    cyc(40);
    chk_vec(synth_word, carrier_word, "tx synth");
    op_mode_sel = MODE_SYNTH_RX_MODE;
    cyc(40);
    chk_vec(synth_word, carrier_word - if_word, "rx synth");
  endtask

  task automatic t_tx(input logic ook);
    ook_select = ook;
    op_mode_sel = MODE_STDBY;
    cyc(30);
    op_mode_sel = MODE_TX;
    wait_lv(tx_on, 1'b1, 40, n);
    chk_rng(n, 9, 11, "tx synth wait");
    wait_lv(mode_ready, 1'b1, 2000, n);
    chk_rng(n, TX_BASE_CYC + (ook ? 0 : 500) - 1, TX_BASE_CYC + (ook ? 0 : 500) + 4,
            "tx startup");
    chk_vec(rx_on, 0, "rx off in tx");
  endtask

  task automatic t_pre(input int i);
    int k;
    preamble_length_select = (i < 4) ? 2'(i) : 2'h1;
    preamble_detector_enable = (i < 4);
    receive_trigger_select = TRIG_PRE;
    enter_rx();
    wait_lv(mode_ready, 1'b1, 9000, k);
    chk_vec(correction_gate, 0, "gate before preamble");
    alt <= 1'b1;
    k = 0;
    while (preamble_found_flag !== 1'b1 && k < 40) begin
      @(negedge clk);
      if (bit_tick) k++;
    end
    if (i < 3) chk_rng(k, 8 * (i + 1) - 2, 8 * (i + 1) + 1, "preamble run");
    else chk_vec(preamble_found_flag, 0, "preamble never");
    chk_vec(correction_gate, i < 3, "gate after preamble");
    alt <= 1'b0;
  endtask

  task automatic t_to(input logic [2:0] code, input logic hi, input logic [2:0] exp);
    logic [2:0] win, bad;
    int k;
    win = 3'h0;
    bad = 3'h0;
    k = 0;
    receive_trigger_select = code;
    signal_level_limit = hi ? 8'h30 : 8'h50;
    enter_rx();
    while (k < 26) begin
      @(negedge clk);
      if (bit_tick) k++;
      if (k >= 15 && k <= 18) win |= {timeout_level, timeout_preamble, timeout_sync};
      else bad |= {timeout_level, timeout_preamble, timeout_sync};
    end
    chk_vec(win, exp, "timeouts in window");
    chk_vec(bad, 0, "timeouts outside window");
    chk_vec(level_flag, hi, "level flag");
  endtask

  task automatic wrap_up();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_boot(1);
    t_cal();
    t_temp();
    t_modes();
    t_tx(1'b0);
    t_tx(1'b1);
    for (int i = 0; i < 5; i++) t_pre(i);
    level_wait_limit = 8'h01;
    preamble_wait_limit = 8'h01;
    sync_wait_limit = 8'h01;
    preamble_length_select = 2'h3;
    t_to(TRIG_LVL, 1'b0, 3'b101);
    t_to(TRIG_PRE, 1'b0, 3'b011);
    t_to(TRIG_BOTH, 1'b0, 3'b110);
    t_to(TRIG_NONE, 1'b0, 3'b000);
    t_to(TRIG_BOTH, 1'b1, 3'b010);
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    t_boot(40);
    wrap_up();
  end
endmodule
`default_nettype wire
